// [rtl/wrxmc_pkg.sv]
package wrxmc_pkg;
  // Clock rate
  localparam int CLK_MHZ = 100;
  // Error packet pacing in ms
  localparam int FAST_ERR_MS = 30;
  localparam int SLOW_ERR_MS = 250;
  localparam int FAST_ERR_CYC = FAST_ERR_MS * CLK_MHZ * 1000;
  localparam int SLOW_ERR_CYC = SLOW_ERR_MS * CLK_MHZ * 1000;
  localparam int PACE_W = 25;
  // Packet headers
  localparam logic [7:0] HDR_END_TRANSFER = 8'h02;
  localparam logic [7:0] HDR_ERROR = 8'h03;
  // Reason codes
  localparam logic [7:0] RSN_UNKNOWN = 8'h00;
  localparam logic [7:0] RSN_CHARGE_DONE = 8'h01;
  localparam logic [7:0] RSN_INT_FAULT = 8'h02;
  localparam logic [7:0] RSN_OVER_TEMP = 8'h03;
  localparam logic [7:0] RSN_OVER_VOLT = 8'h04;
  // Fault thresholds
  localparam int TJ_FAULT_C = 150;
  localparam int ILIM_MIN_OHM = 100;
  // Communication limit in mA
  localparam logic [11:0] CL_KNEE_MA = 12'h12C;
  localparam logic [11:0] CL_FIXED_MA = 12'h190;
  localparam logic [11:0] CL_MARGIN_MA = 12'h032;
  // Decoded modes
  typedef enum logic [1:0] {
    WRXMC_ADAPTER_CTRL,
    WRXMC_NO_COMM_LIMIT,
    WRXMC_OTG,
    WRXMC_SHUTDOWN
  } wrxmc_mode_t;
endpackage : wrxmc_pkg

// [rtl/wrxmc_sync.sv]
`timescale 1ns/1ps
module wrxmc_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Async in, sync out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } wrxmc_sync_st_t;
  wrxmc_sync_st_t st_q;
  wrxmc_sync_st_t st_d;

  always_comb begin
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.s2;
endmodule : wrxmc_sync

// [rtl/wrxmc_top.sv]
`timescale 1ns/1ps
// How it works
// [R1] Error packets every 30 ms, then 250 ms
// [R2] Overvoltage: regulator off, request lower voltage
// [R3] Unsynced or reset mode reads as low
// [R4] Mode 00: adapter first, else wireless, limited
// [R5] Mode 00, no adapter: switch held off
// [R6] Mode 00, adapter present: wireless off, switch on
// [R7] Mode 01: comm limit off, both sources
// [R8] Mode 01 with both present: wireless wins, since b is always 1 in mode 01
// [R9] Mode 10: gate low, OTG on, wireless off
// [R10] Mode 11: all off, reason 0x01
// [R11] Host drives mode select a actively
// [R12] End packet header 0x02 with reason
// [R13] Reason 0x00: adapter, OTG, ctrl high, cold
// [R14] Reason 0x02: hot junction or low resistance
// [R15] Reason 0x03: thermistor hot or ctrl low
// [R16] Reason 0x04: rectifier fails to converge
// [R17] Power good on while output enabled
// [R18] Output off until rectifier converged
// [R19] Terminate when any condition during transfer
// [R20] Limit 400 mA under 300, else +50
// [R21] No reason codes above 0x04
// [R22] Mode pins synchronised before decode
module wrxmc_top #(
  parameter int FAST_CYC = wrxmc_pkg::FAST_ERR_CYC,
  parameter int SLOW_CYC = wrxmc_pkg::SLOW_ERR_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Mode pins from host
  input wire logic mode_select_a,
  input wire logic mode_select_b,
  // Analog comparator flags and output current
  input wire logic adapter_present,
  input wire logic wireless_present,
  input wire logic transfer_active,
  input wire logic input_step,
  input wire logic rectifier_node_at_target,
  input wire logic rectifier_node_over_threshold,
  input wire logic rectifier_node_no_converge,
  input wire logic rectifier_node_noload_converged,
  input wire logic ctrl_high,
  input wire logic ctrl_low,
  input wire logic thermistor_cold,
  input wire logic thermistor_hot,
  input wire logic junction_hot,
  input wire logic ilim_res_low,
  input wire logic [11:0] iout_ma,
  // Packet link
  input wire logic pkt_ready,
  output logic pkt_valid,
  output logic [7:0] pkt_header,
  output logic [7:0] pkt_data,
  // Power path controls and status
  output logic adapter_switch_on,
  output logic wireless_enable,
  output logic regulator_enable,
  output logic otg_enable,
  output logic comm_limit_enable,
  output logic [11:0] comm_limit_ma,
  output logic power_good_out_o,
  output logic power_good_out_oe,
  output logic [7:0] end_reason,
  output logic end_reason_valid
);
  import wrxmc_pkg::*;

  typedef enum logic [1:0] {
    WRXMC_IDLE,
    WRXMC_FAST,
    WRXMC_SLOW
  } wrxmc_pace_t;

  typedef struct packed {
    wrxmc_pace_t pace;
    logic [PACE_W-1:0] cnt;
    logic err_pend;
    logic end_sent;
    logic pkt_valid;
    logic [7:0] pkt_header;
    logic [7:0] pkt_data;
    logic adapter_switch_on;
    logic wireless_enable;
    logic regulator_enable;
    logic otg_enable;
    logic comm_limit_enable;
    logic [11:0] comm_limit_ma;
    logic pg;
    logic [7:0] end_reason;
    logic end_reason_valid;
  } wrxmc_st_t;

  wrxmc_st_t st_q;
  wrxmc_st_t st_d;
  logic [1:0] mode_sync;
  wrxmc_mode_t mode;
  logic [7:0] reason;
  logic reason_valid;

  // Reset forces low like pulldowns
  wrxmc_sync #(.W(2)) u_sync ( // [R22] [R3]
    .clock(clock),
    .rst(rst),
    .din({mode_select_a, mode_select_b}),
    .dout(mode_sync)
  );

  assign mode = wrxmc_mode_t'(mode_sync);

  function automatic logic [11:0] comm_limit(input logic [11:0] iout);
    if (iout < CL_KNEE_MA) begin
      comm_limit = CL_FIXED_MA; // [R20]
    end else begin
      comm_limit = 12'(iout + CL_MARGIN_MA); // [R20]
    end
  endfunction : comm_limit

  // Reason selection in priority order
  always_comb begin
    reason = RSN_UNKNOWN;
    reason_valid = 1'b1;
    if (mode == WRXMC_SHUTDOWN) begin
      reason = RSN_CHARGE_DONE; // [R10]
    end else if (junction_hot || ilim_res_low) begin
      reason = RSN_INT_FAULT; // [R14]
    end else if (thermistor_hot || ctrl_low) begin
      reason = RSN_OVER_TEMP; // [R15]
    end else if (rectifier_node_no_converge) begin
      reason = RSN_OVER_VOLT; // [R16] [R21]
    end else if (adapter_present || mode == WRXMC_OTG || ctrl_high
                 || thermistor_cold) begin
      reason = RSN_UNKNOWN; // [R13]
    end else begin
      reason_valid = 1'b0;
    end
  end

  always_comb begin
    logic terminate;
    logic wired_first;
    logic [PACE_W-1:0] period;
    logic err_tick;
    terminate = 1'b0;
    wired_first = 1'b0;
    period = '0;
    err_tick = 1'b0;
    st_d = st_q;
    st_d.end_reason = reason;
    st_d.end_reason_valid = reason_valid;
    terminate = reason_valid && transfer_active; // [R19]
    // Mode decode
    st_d.otg_enable = 1'b0;
    st_d.comm_limit_enable = 1'b0;
    st_d.adapter_switch_on = 1'b0;
    st_d.wireless_enable = 1'b0;
    unique case (mode)
      WRXMC_ADAPTER_CTRL: begin
        st_d.comm_limit_enable = 1'b1; // [R4]
        st_d.adapter_switch_on = adapter_present; // [R5] [R6]
        st_d.wireless_enable = !adapter_present && wireless_present; // [R4] [R6]
      end
      WRXMC_NO_COMM_LIMIT: begin
        wired_first = !mode_sync[0]; // [R8]
        st_d.adapter_switch_on = adapter_present && (wired_first || !wireless_present); // [R7]
        st_d.wireless_enable = wireless_present && !(wired_first && adapter_present); // [R7]
      end
      WRXMC_OTG: begin
        st_d.otg_enable = 1'b1; // [R9]
      end
      WRXMC_SHUTDOWN: begin
        st_d.wireless_enable = 1'b0; // [R10]
      end
    endcase
    st_d.comm_limit_ma = comm_limit(iout_ma);
    // Output enable gating
    st_d.regulator_enable = st_q.wireless_enable && rectifier_node_noload_converged // [R18]
                            && !rectifier_node_over_threshold && !terminate; // [R2]
    st_d.pg = st_q.regulator_enable; // [R17]
    // Error packet pacing
    unique case (st_q.pace)
      WRXMC_IDLE: begin
        if (transfer_active && (input_step || rectifier_node_over_threshold)) begin
          st_d.pace = WRXMC_FAST; // [R1] [R2]
          st_d.cnt = '0;
          st_d.err_pend = 1'b1;
          err_tick = 1'b1;
        end
      end
      WRXMC_FAST, WRXMC_SLOW: begin
        period = (st_q.pace == WRXMC_FAST) ? PACE_W'(FAST_CYC - 1) : PACE_W'(SLOW_CYC - 1);
        if (st_q.pace == WRXMC_FAST && rectifier_node_at_target && !rectifier_node_over_threshold) begin
          st_d.pace = WRXMC_SLOW; // [R1]
          st_d.cnt = '0;
        end else if (st_q.cnt >= period) begin
          st_d.cnt = '0;
          st_d.err_pend = 1'b1; // [R1]
          err_tick = 1'b1;
        end else begin
          st_d.cnt = st_q.cnt + 1'b1;
        end
        if (!transfer_active) begin
          st_d.pace = WRXMC_IDLE;
          st_d.err_pend = 1'b0;
          err_tick = 1'b0;
        end
      end
      default: st_d.pace = WRXMC_IDLE;
    endcase
    if (!transfer_active) begin
      st_d.end_sent = 1'b0;
    end
    // Packet emitter: end packet first
    if (st_q.pkt_valid) begin
      if (pkt_ready) begin
        st_d.pkt_valid = 1'b0;
      end
    end else if (terminate && !st_q.end_sent) begin
      st_d.pkt_valid = 1'b1;
      st_d.pkt_header = HDR_END_TRANSFER; // [R12]
      st_d.pkt_data = reason; // [R12]
      st_d.end_sent = 1'b1;
    end else if (st_q.err_pend) begin
      st_d.pkt_valid = 1'b1;
      st_d.pkt_header = HDR_ERROR;
      st_d.pkt_data = rectifier_node_over_threshold ? 8'h80 : 8'h00; // [R2]
      st_d.err_pend = err_tick;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pkt_valid = st_q.pkt_valid;
  assign pkt_header = st_q.pkt_header;
  assign pkt_data = st_q.pkt_data;
  assign adapter_switch_on = st_q.adapter_switch_on;
  assign wireless_enable = st_q.wireless_enable;
  assign regulator_enable = st_q.regulator_enable;
  assign otg_enable = st_q.otg_enable;
  assign comm_limit_enable = st_q.comm_limit_enable;
  assign comm_limit_ma = st_q.comm_limit_ma;
  assign power_good_out_o = 1'b0;
  assign power_good_out_oe = st_q.pg; // [R17]
  assign end_reason = st_q.end_reason;
  assign end_reason_valid = st_q.end_reason_valid;

  a_shutdown_reason: assert property (@(posedge clock) disable iff (rst) // [R10]
    mode == WRXMC_SHUTDOWN |=> end_reason == RSN_CHARGE_DONE && end_reason_valid)
    else $error("shutdown reason wrong");
  a_reason_range: assert property (@(posedge clock) disable iff (rst) // [R21]
    end_reason <= RSN_OVER_VOLT) else $error("reason above overvoltage");
  a_otg_gate: assert property (@(posedge clock) disable iff (rst) // [R9]
    mode == WRXMC_OTG |=> !adapter_switch_on && otg_enable && !wireless_enable)
    else $error("otg mode outputs wrong");
  a_adapter_sw: assert property (@(posedge clock) disable iff (rst) // [R6]
    mode == WRXMC_ADAPTER_CTRL && adapter_present |=> adapter_switch_on && !wireless_enable)
    else $error("adapter not connected");
  a_noload_gate: assert property (@(posedge clock) disable iff (rst) // [R18]
    regulator_enable |-> $past(rectifier_node_noload_converged)) else $error("output early");
  a_pg_follow: assert property (@(posedge clock) disable iff (rst) // [R17]
    regulator_enable |=> power_good_out_oe) else $error("power good missing");
  a_ovp_off: assert property (@(posedge clock) disable iff (rst) // [R2]
    rectifier_node_over_threshold |=> !regulator_enable) else $error("regulator on in ovp");
  a_comm_fixed: assert property (@(posedge clock) disable iff (rst) // [R20]
    iout_ma < CL_KNEE_MA |=> comm_limit_ma == CL_FIXED_MA) else $error("limit not fixed");
  a_end_header: assert property (@(posedge clock) disable iff (rst) // [R12]
    $rose(st_q.end_sent) |-> pkt_valid && pkt_header == HDR_END_TRANSFER)
    else $error("end packet header wrong");
  c_end_pkt: cover property (@(posedge clock) pkt_valid && pkt_header == HDR_END_TRANSFER);
  c_slow_pace: cover property (@(posedge clock) st_q.pace == WRXMC_SLOW);
  c_otg: cover property (@(posedge clock) otg_enable);
  c_fast_pace: cover property (@(posedge clock) st_q.pace == WRXMC_FAST);
  a_nolimit_mode: assert property (@(posedge clock) disable iff (rst) // [R7]
    mode == WRXMC_NO_COMM_LIMIT |=> !comm_limit_enable && !otg_enable)
    else $error("comm limit on in mode 01");
  a_wireless_prio: assert property (@(posedge clock) disable iff (rst) // [R8]
    mode == WRXMC_NO_COMM_LIMIT && wireless_present |=> wireless_enable && !adapter_switch_on)
    else $error("wireless priority lost");
  a_shutdown_off: assert property (@(posedge clock) disable iff (rst) // [R10]
    mode == WRXMC_SHUTDOWN |=> !wireless_enable && !adapter_switch_on && !otg_enable)
    else $error("power path on in shutdown");
  a_switch_off: assert property (@(posedge clock) disable iff (rst) // [R5]
    mode == WRXMC_ADAPTER_CTRL && !adapter_present |=> !adapter_switch_on)
    else $error("adapter switch on with no adapter");
  a_comm_track: assert property (@(posedge clock) disable iff (rst) // [R20]
    iout_ma >= CL_KNEE_MA |=> comm_limit_ma == 12'($past(iout_ma) + CL_MARGIN_MA))
    else $error("limit not tracking");
  a_end_data: assert property (@(posedge clock) disable iff (rst) // [R12]
    $rose(st_q.end_sent) |-> pkt_data == end_reason) else $error("end packet reason wrong");
  a_pace_stop: assert property (@(posedge clock) disable iff (rst) // [R1]
    !transfer_active |=> st_q.pace == WRXMC_IDLE) else $error("pacing without transfer");
  a_term_stop: assert property (@(posedge clock) disable iff (rst) // [R19]
    reason_valid && transfer_active |=> !regulator_enable) else $error("output on after end");
endmodule : wrxmc_top

// [tb/wrxmc_tx_model.sv]
`timescale 1ns/1ps
module wrxmc_tx_model (
  // Clock, reset, pacing
  input wire logic clock,
  input wire logic rst,
  input wire logic stall,
  // Packet link
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_header,
  input wire logic [7:0] pkt_data,
  output logic pkt_ready,
  // Last accepted packet
  output logic got,
  output logic [7:0] hdr,
  output logic [7:0] dat
);
  logic [1:0] gap_q;
  // Slow mode accepts on one cycle in four
  assign pkt_ready = !stall || (gap_q == 2'h3);
  always_ff @(posedge clock) begin
    gap_q <= rst ? 2'h0 : gap_q + 2'h1;
    got <= !rst && pkt_valid && pkt_ready;
    if (pkt_valid && pkt_ready) begin
      hdr <= pkt_header;
      dat <= pkt_data;
    end
  end
endmodule : wrxmc_tx_model

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  import wrxmc_pkg::*;
  logic clock = 0, rst = 1, mode_select_a = 0, mode_select_b = 0, stall = 0;
  logic adapter_present = 0, wireless_present = 0, transfer_active = 0, input_step = 0;
  logic rectifier_node_at_target = 0, rectifier_node_over_threshold = 0, rectifier_node_no_converge = 0;
  logic rectifier_node_noload_converged = 0, ctrl_high = 0, ctrl_low = 0, thermistor_cold = 0;
  logic thermistor_hot = 0, junction_hot = 0, ilim_res_low = 0;
  logic [11:0] iout_ma = 12'h000;
  logic pkt_ready, pkt_valid, adapter_switch_on, wireless_enable, regulator_enable;
  logic otg_enable, comm_limit_enable, power_good_out_o, power_good_out_oe, end_reason_valid;
  logic got;
  logic [7:0] pkt_header, pkt_data, end_reason, hdr, dat;
  logic [11:0] comm_limit_ma;
  int bad_count = 0, compares = 0, cyc_n = 0, t0;
  always #5 clock = ~clock;
  wrxmc_top #(.FAST_CYC(20), .SLOW_CYC(50)) u_dut (.clock, .rst, .mode_select_a,
    .mode_select_b, .adapter_present, .wireless_present, .transfer_active, .input_step,
    .rectifier_node_at_target, .rectifier_node_over_threshold, .rectifier_node_no_converge, .rectifier_node_noload_converged,
    .ctrl_high, .ctrl_low, .thermistor_cold, .thermistor_hot, .junction_hot,
    .ilim_res_low, .iout_ma, .pkt_ready, .pkt_valid, .pkt_header, .pkt_data,
    .adapter_switch_on, .wireless_enable, .regulator_enable, .otg_enable,
    .comm_limit_enable, .comm_limit_ma, .power_good_out_o, .power_good_out_oe,
    .end_reason, .end_reason_valid);
  wrxmc_tx_model u_tx (.clock, .rst, .stall, .pkt_valid, .pkt_header, .pkt_data,
    .pkt_ready, .got, .hdr, .dat);
  task automatic finish_test();
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  always @(posedge clock) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_pkt();
    int n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (got !== 1'b1 && n < 200);
    chk("packet seen", 1, n < 200);
  endtask : wait_pkt
  // Reset and set mode pins; host drives both actively
  task automatic start(input logic a, input logic b);
    @(posedge clock);
    rst <= 1;
    transfer_active <= 0;
    mode_select_a <= a;
    mode_select_b <= b;
    cyc(16);
    chk("reset outputs", 0, {pkt_valid, wireless_enable, adapter_switch_on, otg_enable});
    rst <= 0;
    cyc(8);
  endtask : start
  task automatic t_adapter_mode();
    start(0, 0);
    wireless_present <= 1;
    iout_ma <= 12'h0C8;
    cyc(4);
    chk("wireless", 1, wireless_enable);
    chk("switch off", 0, adapter_switch_on);
    chk("limit on", 1, comm_limit_enable);
    chk("limit low", CL_FIXED_MA, comm_limit_ma);
    iout_ma <= 12'h190;
    cyc(4);
    chk("limit track", 12'h1C2, comm_limit_ma);
    chk("pg off", 0, power_good_out_oe);
    rectifier_node_noload_converged <= 1;
    cyc(6);
    chk("regulator", 1, regulator_enable);
    chk("pg on", 2'h1, {power_good_out_o, power_good_out_oe});
    adapter_present <= 1;
    cyc(4);
    chk("adapter", 2'h2, {adapter_switch_on, wireless_enable});
  endtask : t_adapter_mode
  task automatic t_modes();
    start(0, 1);
    adapter_present <= 1;
    cyc(4);
    chk("mode01", 2'h2, {wireless_enable, comm_limit_enable});
    start(1, 0);
    transfer_active <= 1;
    wait_pkt();
    chk("mode10", 3'h1, {adapter_switch_on, wireless_enable, otg_enable});
    chk("end 10", {HDR_END_TRANSFER, RSN_UNKNOWN}, {hdr, dat});
    start(1, 1);
    transfer_active <= 1;
    wait_pkt();
    chk("end 11", {HDR_END_TRANSFER, RSN_CHARGE_DONE}, {hdr, dat});
    chk("mode11", 0, {adapter_switch_on, wireless_enable, regulator_enable});
    transfer_active <= 0;
    adapter_present <= 0;
  endtask : t_modes
  task automatic t_reasons();
    logic [7:0] code [7] = '{8'h02, 8'h02, 8'h03, 8'h03, 8'h04, 8'h00, 8'h00};
    start(0, 0);
    wireless_present <= 1;
    for (int i = 0; i < 7; i++) begin
      stall <= i[0];
      {junction_hot, ilim_res_low, thermistor_hot, ctrl_low, rectifier_node_no_converge, ctrl_high,
        thermistor_cold} <= 7'h40 >> i;
      transfer_active <= 1;
      wait_pkt();
      chk("end header", HDR_END_TRANSFER, hdr);
      chk("end code", code[i], dat);
      chk("reason", {1'b1, code[i]}, {end_reason_valid, end_reason});
      transfer_active <= 0;
      cyc(4);
    end
  endtask : t_reasons
  task automatic t_pacing();
    start(0, 0);
    stall <= 0;
    {junction_hot, ilim_res_low, thermistor_hot, ctrl_low, rectifier_node_no_converge, ctrl_high,
      thermistor_cold} <= 7'h00;
    input_step <= 1;
    transfer_active <= 1;
    wait_pkt();
    input_step <= 0;
    t0 = cyc_n;
    wait_pkt();
    chk("fast gap", 20, cyc_n - t0);
    rectifier_node_at_target <= 1;
    wait_pkt();
    t0 = cyc_n;
    wait_pkt();
    chk("slow gap", 50, cyc_n - t0);
    start(0, 0);
    rectifier_node_over_threshold <= 1;
    transfer_active <= 1;
    wait_pkt();
    chk("ov packet", {HDR_ERROR, 8'h80}, {hdr, dat});
    chk("ov regulator", 0, regulator_enable);
  endtask : t_pacing
  initial begin
    t_adapter_mode();
    t_modes();
    t_reasons();
    t_pacing();
    finish_test();
  end
endmodule : tb
